//--- core/sfp_defines.vh
// Register offsets, field positions, reset values and timing counts for the supply fault protection block
`ifndef SFP_DEFINES_VH
`define SFP_DEFINES_VH

`define SFP_CLK_HZ            100000000
`define SFP_BB_SW_HZ          400000
`define SFP_BK_SW_HZ          2000000
`define SFP_OFF_TIME_US       2000
`define SFP_CLR_WIN_US        2000
`define SFP_BB_RETRY_CYC      ((`SFP_CLK_HZ + `SFP_BB_SW_HZ - 1) / `SFP_BB_SW_HZ)
`define SFP_BK_RETRY_CYC      ((`SFP_CLK_HZ + `SFP_BK_SW_HZ - 1) / `SFP_BK_SW_HZ)
`define SFP_OFF_CYC           ((`SFP_CLK_HZ / 1000000) * `SFP_OFF_TIME_US)
`define SFP_CLR_WIN_CYC       ((`SFP_CLK_HZ / 1000000) * `SFP_CLR_WIN_US)
`define SFP_RETRY_LIMIT       8
`define SFP_POR_CYC           1000

`define SFP_ADDR_STATUS       12'h000
`define SFP_ADDR_MASK         12'h004
`define SFP_ADDR_CFG          12'h008
`define SFP_ADDR_STATE        12'h00c

`define SFP_ST_BB_OC          0
`define SFP_ST_BK_OC          1
`define SFP_ST_SR_OC          2
`define SFP_ST_TRA_OC         3
`define SFP_ST_TRB_OC         4
`define SFP_ST_TRC_OC         5
`define SFP_ST_THERM          6
`define SFP_ST_FREQ           7
`define SFP_ST_OV             8
`define SFP_ST_UV             9
`define SFP_ST_W              10

`define SFP_CFG_BB_LATCH      0
`define SFP_CFG_BK_LATCH      1
`define SFP_CFG_TH_LATCH      2
`define SFP_CFG_RESET         3'h7

`endif

//--- core/sfp_retry.v
// Overcurrent retry and latch-off sequencer for one switching converter
`timescale 1ns/100ps
`include "sfp_defines.vh"

module sfp_retry #(
   parameter RETRY_CYC = 250,
   parameter OFF_CYC   = 200000,
   parameter WIN_CYC   = 200000,
   parameter LIMIT     = 8
) (
   input  wire pclk,
   input  wire presetn,
   input  wire ce,
   input  wire enable,
   input  wire oc_in,
   input  wire latch_mode,
   output reg  drv_on_q,
   output reg  latched_q,
   output reg  oc_event_q
);
   localparam ST_IDLE  = 3'd0;
   localparam ST_RETRY = 3'd1;
   localparam ST_ON    = 3'd2;
   localparam ST_OFF   = 3'd3;
   localparam ST_WIN   = 3'd4;
   localparam ST_LATCH = 3'd5;

   reg [2:0]  state_q;
   reg [31:0] cnt_q;
   reg [3:0]  rep_q;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q    <= ST_IDLE;
         cnt_q      <= 32'h0;
         rep_q      <= 4'h0;
         drv_on_q   <= 1'b0;
         latched_q  <= 1'b0;
         oc_event_q <= 1'b0;
      end else if (ce) begin
         oc_event_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               drv_on_q <= enable;
               if (enable && oc_in) begin
                  // First detection: switch off, retry at switching rate
                  drv_on_q   <= 1'b0;
                  oc_event_q <= 1'b1;
                  cnt_q      <= 32'h0;
                  state_q    <= ST_RETRY;
               end
            end
            ST_RETRY: begin
               if (cnt_q >= RETRY_CYC - 1) begin
                  drv_on_q <= 1'b1;
                  state_q  <= ST_ON;
               end else begin
                  cnt_q <= cnt_q + 32'h1;
               end
            end
            ST_ON: begin
               if (oc_in) begin
                  // Re-detection: hold off for the long off time
                  drv_on_q   <= 1'b0;
                  oc_event_q <= 1'b1;
                  cnt_q      <= 32'h0;
                  // Latch only once all repetitions have run their off period
                  if (latch_mode && rep_q >= LIMIT) begin
                     state_q   <= ST_LATCH;
                     latched_q <= 1'b1;
                  end else begin
                     if (rep_q < LIMIT)
                        rep_q <= rep_q + 4'h1;
                     state_q <= ST_OFF;
                  end
               end else begin
                  cnt_q   <= 32'h0;
                  state_q <= ST_WIN;
               end
            end
            ST_OFF: begin
               if (cnt_q >= OFF_CYC - 1) begin
                  drv_on_q <= 1'b1;
                  cnt_q    <= 32'h0;
                  state_q  <= ST_ON;
               end else begin
                  cnt_q <= cnt_q + 32'h1;
               end
            end
            ST_WIN: begin
               if (oc_in) begin
                  drv_on_q <= 1'b1;
                  state_q  <= ST_ON;
               end else if (cnt_q >= WIN_CYC - 1) begin
                  // Quiet window passed: clear repetitions
                  rep_q   <= 4'h0;
                  state_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q + 32'h1;
               end
            end
            ST_LATCH: begin
               drv_on_q <= 1'b0;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule

//--- core/sfp_top.v
// Supply fault protection: start-up gating, fault latching, diagnostic and APB registers
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "sfp_defines.vh"

// Contract
// - Converter protection at start; diag after self-test
// - Series OC and undervoltage after release
// - Tracking OC ignored until primary reset release
// - Any overcurrent drives diagnostic low
// - Buck-boost off, retry at 400 kHz
// - Re-detect: 2 ms off, latch after 8
// - Quiet window clears repetition counter
// - Buck uses same sequence at 2 MHz
// - Config bit selects continue or latch-off
// - Series limiter recorded, diagnostic latched low
// - Each tracking limiter recorded independently
// - Overheat shuts outputs, latching selectable
// - Frequency fault latches outputs, resets low
// - Reset timer starts after both rails good
// - Status written with diagnostic low
module sfp_top #(
   parameter BB_RETRY_CYC = `SFP_BB_RETRY_CYC,
   parameter BK_RETRY_CYC = `SFP_BK_RETRY_CYC,
   parameter OFF_CYC      = `SFP_OFF_CYC,
   parameter WIN_CYC      = `SFP_CLR_WIN_CYC,
   parameter POR_CYC      = `SFP_POR_CYC
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        ce,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        analog_self_test_done,
   input  wire        bb_start,
   input  wire        bk_start,
   input  wire        sr_start,
   input  wire        tr_start,
   input  wire        bb_oc,
   input  wire        bk_oc,
   input  wire        sr_limit,
   input  wire        tra_limit,
   input  wire        trb_limit,
   input  wire        trc_limit,
   input  wire        bb_ov,
   input  wire        bk_ov,
   input  wire        sr_ov,
   input  wire        tr_ov,
   input  wire        sr_uv,
   input  wire        bk_uv,
   input  wire        tr_uv,
   input  wire        thermal_sensor_a,
   input  wire        thermal_sensor_b,
   input  wire        freq_fault,
   output reg         fault_out_n,
   output reg         primary_reset_out_n,
   output reg         secondary_reset_out_n,
   output reg         bb_drv_en,
   output reg         bk_drv_en,
   output reg         sr_en,
   output reg         tr_en,
   output reg         irq
);
   wire        bb_drv;
   wire        bk_drv;
   wire        bb_lat;
   wire        bk_lat;
   wire        bb_evt;
   wire        bk_evt;
   reg  [10:0] status_q;
   reg  [10:0] mask_q;
   reg  [2:0]  cfg_q;
   reg         diag_lat_q;
   reg         all_off_q;
   reg         sr_rel_q;
   reg         bk_rel_q;
   reg         por_cnt_run_q;
   reg  [31:0] por_cnt_q;
   reg  [10:0] ev;
   reg         therm;
   wire        bus_wr;
   wire        bus_rd;
   wire        hit;

   function addr_hit;
      input [11:0] a;
      begin
         addr_hit = (a == `SFP_ADDR_STATUS) || (a == `SFP_ADDR_MASK) ||
                    (a == `SFP_ADDR_CFG) || (a == `SFP_ADDR_STATE);
      end
   endfunction

   // Converter sequencers enabled from converter start
   sfp_retry #(
      .RETRY_CYC (BB_RETRY_CYC),
      .OFF_CYC   (OFF_CYC),
      .WIN_CYC   (WIN_CYC),
      .LIMIT     (`SFP_RETRY_LIMIT)
   ) u_bb (
      .pclk       (pclk),
      .presetn    (presetn),
      .ce         (ce),
      .enable     (bb_start),
      .oc_in      (bb_oc),
      .latch_mode (cfg_q[`SFP_CFG_BB_LATCH]),
      .drv_on_q   (bb_drv),
      .latched_q  (bb_lat),
      .oc_event_q (bb_evt)
   );

   sfp_retry #(
      .RETRY_CYC (BK_RETRY_CYC),
      .OFF_CYC   (OFF_CYC),
      .WIN_CYC   (WIN_CYC),
      .LIMIT     (`SFP_RETRY_LIMIT)
   ) u_bk (
      .pclk       (pclk),
      .presetn    (presetn),
      .ce         (ce),
      .enable     (bk_start),
      .oc_in      (bk_oc),
      .latch_mode (cfg_q[`SFP_CFG_BK_LATCH]),
      .drv_on_q   (bk_drv),
      .latched_q  (bk_lat),
      .oc_event_q (bk_evt)
   );

   // Gated fault events
   always @* begin
      therm = thermal_sensor_a | thermal_sensor_b;
      ev = 11'h0;
      ev[`SFP_ST_BB_OC]  = analog_self_test_done & (bb_evt | bb_oc);
      ev[`SFP_ST_BK_OC]  = analog_self_test_done & (bk_evt | bk_oc);
      ev[`SFP_ST_SR_OC]  = sr_rel_q & sr_limit;
      ev[`SFP_ST_TRA_OC] = primary_reset_out_n & tra_limit;
      ev[`SFP_ST_TRB_OC] = primary_reset_out_n & trb_limit;
      ev[`SFP_ST_TRC_OC] = primary_reset_out_n & trc_limit;
      ev[`SFP_ST_THERM]  = analog_self_test_done & therm;
      ev[`SFP_ST_FREQ]   = analog_self_test_done & freq_fault;
      ev[`SFP_ST_OV]     = analog_self_test_done & (bb_ov | bk_ov | sr_ov | tr_ov);
      ev[`SFP_ST_UV]     = (sr_rel_q & sr_uv) | (bk_rel_q & bk_uv) |
                           (primary_reset_out_n & tr_uv);
   end

   assign hit    = addr_hit(paddr);
   assign bus_wr = psel & penable & pwrite & pready & hit;
   assign bus_rd = psel & ~penable & ~pwrite;

   // APB slave answers one cycle after setup, zero wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
         mask_q  <= 11'h0;
         cfg_q   <= `SFP_CFG_RESET; // Latch-off is the default response
      end else if (ce) begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~addr_hit(paddr);
         if (bus_rd) begin
            case (paddr)
               `SFP_ADDR_STATUS: prdata <= {21'h0, status_q};
               `SFP_ADDR_MASK:   prdata <= {21'h0, mask_q};
               `SFP_ADDR_CFG:    prdata <= {29'h0, cfg_q};
               `SFP_ADDR_STATE:  prdata <= {24'h0, bb_lat, bk_lat, all_off_q, diag_lat_q,
                                             sr_rel_q, bk_rel_q, primary_reset_out_n, secondary_reset_out_n};
               default:          prdata <= 32'h0;
            endcase
         end
         if (bus_wr && paddr == `SFP_ADDR_MASK)
            mask_q <= pwdata[10:0];
         if (bus_wr && paddr == `SFP_ADDR_CFG)
            cfg_q <= pwdata[2:0];
      end
   end

   // Status flags: event wins over write-one-to-clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q   <= 11'h0;
         diag_lat_q <= 1'b0;
         irq        <= 1'b0;
      end else if (ce) begin
         status_q <= (status_q & ~((bus_wr && paddr == `SFP_ADDR_STATUS) ? pwdata[10:0] : 11'h0)) | ev;
         if (|ev)
            diag_lat_q <= 1'b1;
         // A set mask bit hides its status bit from the interrupt
         irq <= |(((status_q & ~((bus_wr && paddr == `SFP_ADDR_STATUS) ? pwdata[10:0] : 11'h0)) | ev) & ~mask_q);
      end
   end

   // Start-up release tracking and reset timer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sr_rel_q              <= 1'b0;
         bk_rel_q              <= 1'b0;
         por_cnt_run_q         <= 1'b0;
         por_cnt_q             <= 32'h0;
         primary_reset_out_n   <= 1'b0;
         secondary_reset_out_n <= 1'b0;
      end else if (ce) begin
         if (sr_start && !sr_uv)
            sr_rel_q <= 1'b1;
         if (bk_start && !bk_uv)
            bk_rel_q <= 1'b1;
         if (status_q[`SFP_ST_FREQ] || ev[`SFP_ST_FREQ]) begin
            // Frequency fault forces both resets low
            primary_reset_out_n   <= 1'b0;
            secondary_reset_out_n <= 1'b0;
            por_cnt_run_q         <= 1'b0;
         end else if (sr_rel_q && bk_rel_q && !primary_reset_out_n) begin
            por_cnt_run_q <= 1'b1;
            if (por_cnt_q >= POR_CYC - 1) begin
               primary_reset_out_n   <= 1'b1;
               secondary_reset_out_n <= 1'b1;
            end else begin
               por_cnt_q <= por_cnt_q + 32'h1;
            end
         end
      end
   end

   // Output latch-off and pin drive
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         all_off_q   <= 1'b0;
         fault_out_n <= 1'b1;
         bb_drv_en   <= 1'b0;
         bk_drv_en   <= 1'b0;
         sr_en       <= 1'b0;
         tr_en       <= 1'b0;
      end else if (ce) begin
         if (ev[`SFP_ST_FREQ] || (ev[`SFP_ST_THERM] && cfg_q[`SFP_CFG_TH_LATCH]))
            all_off_q <= 1'b1;
         fault_out_n <= ~(diag_lat_q | (|ev));
         if (all_off_q || ev[`SFP_ST_FREQ] || therm) begin
            bb_drv_en <= 1'b0;
            bk_drv_en <= 1'b0;
            sr_en     <= 1'b0;
            tr_en     <= 1'b0;
         end else begin
            bb_drv_en <= bb_drv;
            bk_drv_en <= bk_drv;
            sr_en     <= sr_start;
            tr_en     <= tr_start;
         end
      end
   end
endmodule

//--- verification/sfp_checker.sv
// Concurrent checks on the supply fault protection top-level ports
`timescale 1ns/100ps
module sfp_checker (
   input logic pclk,
   input logic presetn,
   input logic ce,
   input logic analog_self_test_done,
   input logic bb_start,
   input logic bk_start,
   input logic sr_start,
   input logic bb_oc,
   input logic bk_oc,
   input logic sr_limit,
   input logic sr_uv,
   input logic thermal_sensor_a,
   input logic thermal_sensor_b,
   input logic freq_fault,
   input logic fault_out_n,
   input logic primary_reset_out_n,
   input logic secondary_reset_out_n,
   input logic bb_drv_en,
   input logic bk_drv_en,
   input logic sr_en,
   input logic tr_en,
   input logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire all_off = !(bb_drv_en || bk_drv_en || sr_en || tr_en);
   wire run_ok  = ce && analog_self_test_done;
   a_diag_sticky: assert property (!fault_out_n |=> !fault_out_n) else $error("diag released");
   a_oc_diag: assert property (run_ok && (bb_start && bb_oc || bk_start && bk_oc) |-> ##[1:2] !fault_out_n)
      else $error("overcurrent not reported");
   a_sr_diag: assert property (run_ok && sr_start && $past(sr_start) && sr_limit && !sr_uv && $past(!sr_uv)
      |-> ##[1:2] !fault_out_n) else $error("limiter not reported");
   a_freq_rst: assert property (run_ok && freq_fault
      |-> ##[1:2] (!primary_reset_out_n && !secondary_reset_out_n && !fault_out_n)) else $error("freq no reset");
   a_freq_off: assert property (run_ok && freq_fault |-> ##[1:2] all_off) else $error("freq outputs on");
   a_heat_off: assert property (run_ok && (thermal_sensor_a || thermal_sensor_b) |-> ##[1:2] all_off)
      else $error("overheat outputs on");
   a_irq_diag: assert property (irq |-> !fault_out_n) else $error("irq without diag");
   a_oc_drv_off: assert property (ce && bb_start && bb_oc && bb_drv_en |-> ##[1:2] !bb_drv_en)
      else $error("driver not off");
   c_diag: cover property ($fell(fault_out_n));
   c_reset: cover property ($rose(primary_reset_out_n));
   c_retry: cover property ($fell(bb_drv_en) ##[1:100] $rose(bb_drv_en));
endmodule
bind sfp_top sfp_checker u_chk (.pclk, .presetn, .ce, .analog_self_test_done, .bb_start, .bk_start, .sr_start,
   .bb_oc, .bk_oc, .sr_limit, .sr_uv, .thermal_sensor_a, .thermal_sensor_b, .freq_fault, .fault_out_n,
   .primary_reset_out_n, .secondary_reset_out_n, .bb_drv_en, .bk_drv_en, .sr_en, .tr_en, .irq);

//--- verification/sfp_mcu_model.sv
// Controller model that watches the diagnostic line
`timescale 1ns/100ps
module sfp_mcu_model (
   input  logic pclk,
   input  logic presetn,
   input  logic fault_out_n,
   output logic diag_seen
);
   // Remembers an alarm so the flags can be fetched later
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         diag_seen <= 1'h0;
      end else if (!fault_out_n) begin
         diag_seen <= 1'h1;
      end
   end
endmodule

//--- verification/sfp_top_tb_top.sv
// Self-checking bench for the supply fault protection block
`timescale 1ns/100ps
`include "sfp_defines.vh"
module sfp_top_tb_top;
   localparam int OFF_C = 50;
   localparam int WIN_C = 50;
   localparam int POR_C = 20;
   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, ev, diag_seen;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic        analog_self_test_done, bb_start, bk_start, sr_start, tr_start, bb_oc, bk_oc, sr_limit;
   logic        tra_limit, trb_limit, trc_limit, bb_ov, bk_ov, sr_ov, tr_ov, sr_uv, bk_uv, tr_uv;
   logic        thermal_sensor_a, thermal_sensor_b, freq_fault, fault_out_n, primary_reset_out_n, irq;
   logic        secondary_reset_out_n, bb_drv_en, bk_drv_en, sr_en, tr_en;
   int          miscompares, n_checks, k;
   sfp_top #(.BB_RETRY_CYC(10), .BK_RETRY_CYC(2), .OFF_CYC(OFF_C), .WIN_CYC(WIN_C), .POR_CYC(POR_C)) DUT (
      .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .analog_self_test_done, .bb_start, .bk_start, .sr_start, .tr_start, .bb_oc, .bk_oc, .sr_limit,
      .tra_limit, .trb_limit, .trc_limit, .bb_ov, .bk_ov, .sr_ov, .tr_ov, .sr_uv, .bk_uv, .tr_uv,
      .thermal_sensor_a, .thermal_sensor_b, .freq_fault, .fault_out_n, .primary_reset_out_n,
      .secondary_reset_out_n, .bb_drv_en, .bk_drv_en, .sr_en, .tr_en, .irq);
   sfp_mcu_model mcu (.pclk, .presetn, .fault_out_n, .diag_seen);
   initial begin
      pclk = 1'h0;
      forever #5 pclk = ~pclk;
   end
   task chk(input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask
   task wt(input int c);
      repeat (c) @(posedge pclk);
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'h1 && n < 20);
      chk(n < 20, 1'h1);
      rv = prdata;
      ev = pslverr;
      psel <= 1'h0; penable <= 1'h0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'h0, a, 32'h0);
      chk(rv, x);
   endtask
   task rst;
      presetn <= 1'h0;
      {analog_self_test_done, bb_start, bk_start, sr_start, tr_start, bb_oc, bk_oc} <= 7'h0;
      {sr_limit, tra_limit, trb_limit, trc_limit, thermal_sensor_a, thermal_sensor_b, freq_fault} <= 7'h0;
      {sr_uv, bk_uv, tr_uv} <= 3'h7;
      wt(12);
      presetn <= 1'h1;
   endtask
   task up;
      @(posedge pclk);
      analog_self_test_done <= 1'h1; {bb_start, bk_start, sr_start, tr_start} <= 4'hf; {sr_uv, bk_uv, tr_uv} <= 3'h0;
   endtask
   task rel;
      k = 0;
      while (primary_reset_out_n !== 1'h1 && k < POR_C + 50) begin wt(1); k++; end
      chk(primary_reset_out_n, 1'h1);
   endtask
   // Counts driver re-enables under overcurrent until stop re-enables are seen or a long off span shows a latch
   task run(input logic s, input int stop);
      logic p, v;
      int   q;
      p = 1'h1; q = 0; k = 0;
      while (q < 200 && k < stop) begin
         wt(1);
         v = s ? bk_drv_en : bb_drv_en;
         if (v === 1'h1) q = 0; else q++;
         if (v === 1'h1 && p !== 1'h1) k++;
         p = v;
      end
   endtask
   task t_start;
      rst; bb_start <= 1'h1; bb_oc <= 1'h1; wt(5);
      chk(fault_out_n, 1'h1);
      bb_oc <= 1'h0; up; tra_limit <= 1'h1; wt(4);
      chk(fault_out_n, 1'h1);
      rd(`SFP_ADDR_STATUS, 32'h0);
      rel; wt(3);
      chk(fault_out_n, 1'h0);
      rd(`SFP_ADDR_STATUS, 32'h8);
      chk(irq, 1'h1);
      apb(1'h1, `SFP_ADDR_MASK, 32'h8); wt(2); chk(irq, 1'h0);
      apb(1'h1, `SFP_ADDR_MASK, 32'h0); tra_limit <= 1'h0; apb(1'h1, `SFP_ADDR_STATUS, 32'h8); wt(2);
      rd(`SFP_ADDR_STATUS, 32'h0); chk(irq, 1'h0);
      chk(fault_out_n, 1'h0);
      trb_limit <= 1'h1; sr_limit <= 1'h1; wt(3);
      rd(`SFP_ADDR_STATUS, 32'h14);
      rd(`SFP_ADDR_CFG, 32'h7);
      rd(12'h010, 32'h0); chk(ev, 1'h1);
      chk(diag_seen, 1'h1);
      $display("startup test done");
   endtask
   task t_bb;
      rst; up; rel; wt(5);
      bb_oc <= 1'h1; run(1'h0, 4); bb_oc <= 1'h0; wt(OFF_C + WIN_C + 40);
      chk(bb_drv_en, 1'h1);
      bb_oc <= 1'h1; run(1'h0, 99);
      chk(k, 9);
      chk(bb_drv_en, 1'h0);
      apb(1'h1, `SFP_ADDR_CFG, 32'h5); bk_oc <= 1'h1; run(1'h1, 12);
      chk(k, 12);
      apb(1'h0, `SFP_ADDR_STATE, 32'h0);
      chk(rv & 32'hc0, 32'h80);
      chk(fault_out_n, 1'h0);
      bk_oc <= 1'h0;
      $display("converter retry test done");
   endtask
   task t_heat;
      rst; up; rel; apb(1'h1, `SFP_ADDR_CFG, 32'h3);
      thermal_sensor_a <= 1'h1; wt(3);
      chk(sr_en, 1'h0);
      thermal_sensor_a <= 1'h0; wt(10);
      chk({sr_en, fault_out_n}, 2'h2);
      rst; up; rel; thermal_sensor_b <= 1'h1; wt(3); thermal_sensor_b <= 1'h0; wt(10);
      chk({sr_en, tr_en, bk_drv_en, bb_drv_en}, 4'h0);
      $display("overheat test done");
   endtask
   task t_freq;
      rst; up; rel; freq_fault <= 1'h1; wt(3); freq_fault <= 1'h0; wt(10);
      chk({primary_reset_out_n, secondary_reset_out_n, fault_out_n, sr_en, tr_en}, 5'h0);
      $display("frequency test done");
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      {ce, psel, penable, pwrite, bb_ov, bk_ov, sr_ov, tr_ov} = 8'h80;
      paddr = 12'h0; pwdata = 32'h0; miscompares = 0; n_checks = 0;
      rst; t_start; t_bb; t_heat; t_freq; conclude;
   end
   initial begin
      wt(60000);
      miscompares++;
      conclude;
   end
endmodule
